// ---- core/ipp_cfg.svh ----
// constants for the interrupt priority and pending controller
`ifndef IPP_CFG_SVH
`define IPP_CFG_SVH
// -------------------------------------------------------------------------
// register byte offsets (word aligned)
// -------------------------------------------------------------------------
`define IPP_OFF_SET_EN 8'h00
`define IPP_OFF_CLR_EN 8'h04
`define IPP_OFF_SET_PEND 8'h08
`define IPP_OFF_CLR_PEND 8'h0c
`define IPP_OFF_CTRL_STATE 8'h10
`define IPP_OFF_MASK 8'h14
`define IPP_OFF_PRIO_BASE 8'h20
`define IPP_PRIO_REGS 5
// -------------------------------------------------------------------------
// field positions
// -------------------------------------------------------------------------
`define IPP_ACTIVE_LSB 0
`define IPP_PEND_NUM_LSB 12
`define IPP_ANY_PEND_BIT 22
`define IPP_MASK_BIT 0
`define IPP_NUM_LINES 20
`define IPP_IRQ_BASE 9'h010
`define IPP_EXC_RESET 9'h001
`define IPP_EXC_NMI 9'h002
`define IPP_EXC_HARD 9'h003
`define IPP_NEST_DEPTH 4
`define IPP_PRIO_RESET 2'h0
`define IPP_LVL_NONE 3'h7
`endif

// ---- core/ipp_pkg.sv ----
// types for the interrupt priority and pending controller
package ipp_pkg;
  // exception number and effective priority level (0..2 fixed, 3..6 config)
  typedef struct packed {
    logic [8:0] num;
    logic [2:0] lvl;
  } ipp_exc_type;
  // handshake from the core
  typedef struct packed {
    logic take;
    logic done;
  } ipp_core_type;
  typedef enum logic [2:0] {
    IPP_IDLE = 3'b001,
    IPP_ACK = 3'b010,
    IPP_REL = 3'b100
  } ipp_bus_state_type;
endpackage

// ---- core/ipp_ctrl.sv ----
// interrupt priority and pending controller with wishbone registers
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ipp_cfg.svh"

// Overview of operation
// - reset, nmi, hard fault have fixed top priority
// - others use levels 0..3, lower wins
// - preempt only strictly higher, then resume interrupted
// - up to four nested active exceptions
// - equal priority: smallest exception number first
// - priority word holds four 2-bit fields
// - disabled lines do not pend from requests; software-pended ones are processed
// - set-enable writes ones, reads enable state
// - clear-enable writes ones, reads enable state
// - enable registers only touch lines 0..19
// - mask bit blocks configurable exceptions, keeps pending
// - track inactive, pending, active, active and pending
// - bits 8:0 show executing exception, zero idle
// - bits 20:12 show top pending exception
// - bit 22 shows any line pending
// - request pends; handler start makes it active
// - set-pending writes ones, reads pending state
// - clear-pending writes ones, reads pending state
// - repeated set pends only once
// - pending writable always; a pended disabled line is still arbitrated
// - pending registers only touch lines 0..19
// - line n reports as exception n plus 16
module ipp_ctrl #(
  parameter int NLINES = `IPP_NUM_LINES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [NLINES-1:0] irq_i,
  input wire logic reset_exc_i,
  input wire logic nmi_i,
  input wire logic hard_fault_i,
  input wire ipp_pkg::ipp_core_type core_i,
  output logic exc_req_o,
  output logic [8:0] exc_num_o,
  output logic [8:0] active_exc_number_o,
  output logic [2:0] nest_depth_o
);
  import ipp_pkg::*;

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  logic [NLINES-1:0] enable_q;
  logic [NLINES-1:0] pend_q;
  logic [NLINES-1:0] act_q;
  logic [1:0] prio_q [NLINES];
  logic mask_bit_q;
  logic [2:0] sys_pend_q;
  logic [2:0] sys_act_q;
  logic [NLINES-1:0] irq_s1_q;
  logic [NLINES-1:0] irq_s2_q;
  ipp_exc_type stack_q [`IPP_NEST_DEPTH];
  logic [2:0] depth_q;
  ipp_bus_state_type bus_q;
  ipp_exc_type top_d;
  ipp_exc_type cur;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_d;
  logic [31:0] wmask;
  logic take_ok;
  logic serve_ok;
  logic [NLINES-1:0] pend_clr;
  logic [NLINES-1:0] pend_set;

  // byte lane mask from sel
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // is the address one of the word-aligned priority words
  function automatic logic is_prio(input logic [7:0] a);
    is_prio = (a >= `IPP_OFF_PRIO_BASE) &&
              (a < `IPP_OFF_PRIO_BASE + 8'(4 * `IPP_PRIO_REGS)) &&
              (a[1:0] == 2'h0);
  endfunction

  assign wmask = lane_mask(sel_i) & dat_i;
  assign wr_en = (bus_q == IPP_IDLE) && cyc_i && stb_i && we_i;
  assign rd_en = (bus_q == IPP_IDLE) && cyc_i && stb_i && !we_i;

  // -----------------------------------------------------------------------
  // wishbone slave: one wait state, ack one cycle, then release
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= IPP_IDLE;
      ack_o <= 1'b0;
    end else begin
      case (bus_q)
        IPP_IDLE: begin
          if (cyc_i && stb_i) begin
            bus_q <= IPP_ACK;
            ack_o <= 1'b1;
          end
        end
        IPP_ACK: begin
          bus_q <= IPP_REL;
          ack_o <= 1'b0;
        end
        IPP_REL: begin
          // wait for the master to drop the strobe
          if (!(cyc_i && stb_i)) begin
            bus_q <= IPP_IDLE;
          end
        end
        default: begin
          bus_q <= IPP_IDLE;
          ack_o <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // input synchronisers for peripheral lines
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
    end else begin
      irq_s1_q <= irq_i;
      irq_s2_q <= irq_s1_q;
    end
  end

  // -----------------------------------------------------------------------
  // enable bits; unused upper bits never stored
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= '0;
    end else if (wr_en && adr_i == `IPP_OFF_SET_EN) begin
      enable_q <= enable_q | wmask[NLINES-1:0];
    end else if (wr_en && adr_i == `IPP_OFF_CLR_EN) begin
      enable_q <= enable_q & ~wmask[NLINES-1:0];
    end
  end

  // global mask bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_bit_q <= 1'b0;
    end else if (wr_en && adr_i == `IPP_OFF_MASK && sel_i[0]) begin
      mask_bit_q <= dat_i[`IPP_MASK_BIT];
    end
  end

  // priority fields at bits 7:6, 15:14, 23:22, 31:30 of each word
  for (genvar g = 0; g < NLINES; g++) begin : g_prio
    localparam int W = g / 4;
    localparam int S = g % 4;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        prio_q[g] <= `IPP_PRIO_RESET;
      end else if (wr_en && adr_i == `IPP_OFF_PRIO_BASE + 8'(4 * W) &&
                   sel_i[S]) begin
        prio_q[g] <= dat_i[8*S+6 +: 2];
      end
    end
  end

  // -----------------------------------------------------------------------
  // pending bits: hardware set wins over software clear
  // -----------------------------------------------------------------------
  always_comb begin
    pend_clr = '0;
    pend_set = '0;
    if (wr_en && adr_i == `IPP_OFF_CLR_PEND) begin
      pend_clr = wmask[NLINES-1:0];
    end
    if (wr_en && adr_i == `IPP_OFF_SET_PEND) begin
      pend_set = wmask[NLINES-1:0];
    end
    // handler start moves the line to active
    if (take_ok && top_d.num >= `IPP_IRQ_BASE) begin
      pend_clr[5'(top_d.num - `IPP_IRQ_BASE)] = 1'b1;
    end
    // a request on a disabled line does not pend
    pend_set = pend_set | (irq_s2_q & enable_q);
  end

  // set is applied after clear so a request in the same cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | pend_set;
    end
  end

  // system exceptions: pend on request, no software access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_pend_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (take_ok && top_d.num == 9'(i + 1)) begin
          sys_pend_q[i] <= 1'b0;
        end
      end
      if (reset_exc_i) sys_pend_q[0] <= 1'b1;
      if (nmi_i) sys_pend_q[1] <= 1'b1;
      if (hard_fault_i) sys_pend_q[2] <= 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // arbitration: fixed levels 0..2, configurable levels 3..6
  // -----------------------------------------------------------------------
  always_comb begin
    top_d.num = 9'h000;
    top_d.lvl = `IPP_LVL_NONE;
    // lower number scanned first wins ties by strict compare
    for (int i = 0; i < 3; i++) begin
      if (sys_pend_q[i] && 3'(i) < top_d.lvl) begin
        top_d.num = 9'(i + 1);
        top_d.lvl = 3'(i);
      end
    end
    for (int i = 0; i < NLINES; i++) begin
      if (pend_q[i] &&
          (3'(prio_q[i]) + 3'h3) < top_d.lvl) begin
        top_d.num = `IPP_IRQ_BASE + 9'(i);
        top_d.lvl = 3'(prio_q[i]) + 3'h3;
      end
    end
  end

  // running handler's level; none when in thread mode
  always_comb begin
    cur.num = 9'h000;
    cur.lvl = `IPP_LVL_NONE;
    if (depth_q != 3'h0) cur = stack_q[2'(depth_q - 3'h1)];
  end

  // the mask holds back configurable lines only; they stay pending and
  // visible in the status word so software can see what is waiting
  assign serve_ok = !(mask_bit_q && top_d.num >= `IPP_IRQ_BASE);

  // preempt only when strictly higher and nesting has room
  assign take_ok = core_i.take && exc_req_o && serve_ok &&
                   top_d.lvl < cur.lvl &&
                   depth_q < 3'(`IPP_NEST_DEPTH);

  // -----------------------------------------------------------------------
  // active nesting stack; return pops back to the interrupted handler
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      depth_q <= 3'h0;
      act_q <= '0;
      sys_act_q <= '0;
      for (int i = 0; i < `IPP_NEST_DEPTH; i++) begin
        stack_q[i] <= '{num: 9'h000, lvl: `IPP_LVL_NONE};
      end
    end else if (take_ok) begin
      stack_q[2'(depth_q)] <= top_d;
      depth_q <= depth_q + 3'h1;
      if (top_d.num >= `IPP_IRQ_BASE) begin
        act_q[5'(top_d.num - `IPP_IRQ_BASE)] <= 1'b1;
      end else begin
        sys_act_q[2'(top_d.num - 9'h001)] <= 1'b1;
      end
    end else if (core_i.done && depth_q != 3'h0) begin
      depth_q <= depth_q - 3'h1;
      if (cur.num >= `IPP_IRQ_BASE) begin
        act_q[5'(cur.num - `IPP_IRQ_BASE)] <= 1'b0;
      end else begin
        sys_act_q[2'(cur.num - 9'h001)] <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // core-facing outputs, all registered
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_req_o <= 1'b0;
      exc_num_o <= 9'h000;
      active_exc_number_o <= 9'h000;
      nest_depth_o <= 3'h0;
    end else begin
      exc_req_o <= (top_d.lvl < cur.lvl) && serve_ok &&
                   depth_q < 3'(`IPP_NEST_DEPTH) && !take_ok;
      exc_num_o <= top_d.num;
      active_exc_number_o <= take_ok ? top_d.num :
                             (core_i.done && depth_q != 3'h0) ?
                             ((depth_q > 3'h1) ?
                              stack_q[2'(depth_q - 3'h2)].num : 9'h000) :
                             cur.num;
      nest_depth_o <= depth_q;
    end
  end

  // -----------------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    case (adr_i)
      `IPP_OFF_SET_EN, `IPP_OFF_CLR_EN: rd_d[NLINES-1:0] = enable_q;
      `IPP_OFF_SET_PEND, `IPP_OFF_CLR_PEND: rd_d[NLINES-1:0] = pend_q;
      `IPP_OFF_CTRL_STATE: begin
        rd_d[`IPP_ACTIVE_LSB +: 9] = cur.num;
        rd_d[`IPP_PEND_NUM_LSB +: 9] = top_d.num;
        rd_d[`IPP_ANY_PEND_BIT] = |pend_q;
      end
      `IPP_OFF_MASK: rd_d[`IPP_MASK_BIT] = mask_bit_q;
      default: begin
        if (is_prio(adr_i)) begin
          for (int i = 0; i < NLINES; i++) begin
            if (adr_i == `IPP_OFF_PRIO_BASE + 8'(4 * (i / 4))) begin
              rd_d[8*(i%4)+6 +: 2] = prio_q[i];
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      dat_o <= rd_d;
    end
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  a_nest_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    depth_q <= 3'(`IPP_NEST_DEPTH)) else $error("nest too deep");
  a_mask_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    take_ok && mask_bit_q |-> top_d.num < `IPP_IRQ_BASE)
    else $error("masked irq taken");
  a_fixed_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    sys_pend_q[1] |-> top_d.num == 9'h001 || top_d.num == 9'h002)
    else $error("nmi outranked");
  a_pend_stays: assert property (@(posedge clk_i) disable iff (rst_i)
    pend_q[0] && !take_ok && !(wr_en && adr_i == `IPP_OFF_CLR_PEND)
    |=> pend_q[0]) else $error("pending lost");
  a_set_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && adr_i == `IPP_OFF_SET_EN && sel_i[0] && dat_i[0]
    |=> enable_q[0]) else $error("enable not set");
  a_clr_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && adr_i == `IPP_OFF_CLR_EN && sel_i[0] && dat_i[0]
    |=> !enable_q[0]) else $error("enable not cleared");
  a_disabled_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_q[1] && !pend_q[1] && !wr_en |=> !pend_q[1])
    else $error("disabled line pended");
  a_preempt_hi: assert property (@(posedge clk_i) disable iff (rst_i)
    take_ok |-> top_d.lvl < cur.lvl ##1 depth_q == $past(depth_q) + 3'h1)
    else $error("bad preemption");
  a_active_mark: assert property (@(posedge clk_i) disable iff (rst_i)
    depth_q != 3'h0 && cur.num >= `IPP_IRQ_BASE |->
    act_q[5'(cur.num - `IPP_IRQ_BASE)]) else $error("active bit lost");
  a_sys_active: assert property (@(posedge clk_i) disable iff (rst_i)
    depth_q != 3'h0 && cur.num < `IPP_IRQ_BASE |->
    sys_act_q[2'(cur.num - 9'h001)]) else $error("system active lost");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack too long");
endmodule // ipp_ctrl
`default_nettype wire

// ---- bench/ipp_core_model.sv ----
// behavioural model of the core that consumes exceptions
`timescale 1ns/10ps
`default_nettype none
module ipp_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic accept_i,
  input wire logic finish_i,
  input wire logic exc_req_i,
  output var ipp_pkg::ipp_core_type core_o
);
  import ipp_pkg::*;
  logic take_q;
  logic done_q;
  // take is a one-cycle pulse; the guard stops a second take while the
  // controller is still retiring the first one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      take_q <= 1'b0;
    end else begin
      take_q <= accept_i && exc_req_i && !take_q;
    end
  end
  // handler return is a one-cycle pulse commanded by the bench
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= finish_i;
    end
  end
  assign core_o = '{take: take_q, done: done_q};
endmodule // ipp_core_model
`default_nettype wire

// ---- bench/interrupt_priority_pending_ctrl_tb.sv ----
// self-checking bench for the interrupt priority and pending controller
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_pending_ctrl_tb;
  import ipp_pkg::*;
  logic clk, rst, cyc, stb, we, ack, nmi, hf, req, accept, finish, rexc;
  logic [7:0] adr;
  logic [3:0] sel, lanes;
  logic [31:0] wdat, rdat, r, c, q;
  logic [19:0] irq;
  logic [8:0] enum_o, act;
  logic [2:0] depth;
  ipp_core_type core;
  logic [1:0] pr [20];
  int mismatches, samples_checked;
  int seed = 32'h8033;
  // ---------------------------------------------------------------
  // design and core model
  // ---------------------------------------------------------------
  ipp_ctrl u_ipp_ctrl (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .irq_i(irq), .reset_exc_i(rexc), .nmi_i(nmi),
    .hard_fault_i(hf), .core_i(core), .exc_req_o(req), .exc_num_o(enum_o),
    .active_exc_number_o(act), .nest_depth_o(depth));
  ipp_core_model u_ipp_core_model (.clk_i(clk), .rst_i(rst),
    .accept_i(accept), .finish_i(finish), .exc_req_i(req), .core_o(core));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic results();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] o);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= d;
    @(posedge clk);
    // only the watchdog ends a wait for the answer
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    o = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] o;
    wb(1'b0, a, 32'h0, o);
    chk(o, exp);
  endtask
  // wait for the active number, let it settle, then compare all views
  task automatic exp_act(input logic [8:0] n, input logic [2:0] d);
    int i;
    logic [31:0] o;
    i = 0;
    // let a strobe issued just now reach the outputs first
    repeat (2) @(posedge clk);
    while (act !== n && i < 40) begin
      @(posedge clk);
      i++;
    end
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h10, 32'h0, o);
    chk({11'h0, o[8:0], act, depth}, {11'h0, n, n, d});
  endtask
  task automatic ret();
    finish <= 1'b1;
    @(posedge clk);
    finish <= 1'b0;
  endtask
  // expected top pending line: lowest level wins, ties to lowest line
  function automatic logic [8:0] top(input logic [19:0] p);
    logic [2:0] best;
    logic [8:0] num;
    best = 3'h4;
    num = 9'h0;
    for (int i = 0; i < 20; i++) begin
      if (p[i] && {1'b0, pr[i]} < best) begin
        best = {1'b0, pr[i]};
        num = 9'h010 + 9'(i);
      end
    end
    return num;
  endfunction
  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    results();
  end
  initial begin
    {cyc, stb, we, nmi, hf, accept, finish, rexc} = '0;
    adr = 8'h0;
    sel = 4'hf;
    lanes = 4'hf;
    wdat = 32'h0;
    irq = 20'h0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    // enable set/clear with random patterns, upper bits ignored
    r = $random(seed);
    wb(1'b1, 8'h00, r, q);
    rd(8'h00, {12'h0, r[19:0]});
    rd(8'h04, {12'h0, r[19:0]});
    c = $random(seed);
    wb(1'b1, 8'h04, c, q);
    rd(8'h00, {12'h0, r[19:0] & ~c[19:0]});
    wb(1'b1, 8'h00, 32'h0, q);
    rd(8'h04, {12'h0, r[19:0] & ~c[19:0]});
    wb(1'b1, 8'h18, r, q);
    rd(8'h18, 32'h0);
    wb(1'b1, 8'h00, 32'hffffffff, q);
    // random priorities and pending sets, core not accepting
    for (int k = 0; k < 4; k++) begin
      for (int w = 0; w < 5; w++) begin
        r = $random(seed);
        wb(1'b1, 8'h20 + 8'(4 * w), r, q);
        for (int j = 0; j < 4; j++) pr[4 * w + j] = r[8 * j + 6 +: 2];
        rd(8'h20 + 8'(4 * w), r & 32'hc0c0c0c0);
      end
      r = (k == 0) ? 32'hffffffff : $random(seed);
      wb(1'b1, 8'h08, r, q);
      rd(8'h08, {12'h0, r[19:0]});
      wb(1'b0, 8'h10, 32'h0, q);
      chk({22'h0, q[22], q[20:12]}, {22'h0, |r[19:0], top(r[19:0])});
      chk({23'h0, enum_o}, {23'h0, top(r[19:0])});
      c = $random(seed);
      wb(1'b1, 8'h0c, c, q);
      rd(8'h0c, {12'h0, r[19:0] & ~c[19:0]});
      wb(1'b1, 8'h0c, 32'hffffffff, q);
    end
    // only the selected byte lane takes a priority write
    lanes = 4'h2;
    wb(1'b1, 8'h24, 32'hffffffff, q);
    lanes = 4'hf;
    rd(8'h24, {pr[7], 6'h0, pr[6], 6'h0, 2'h3, 6'h0, pr[4], 6'h0});
    // disabled line holds off its request until enabled
    wb(1'b1, 8'h04, 32'h8, q);
    irq[3] <= 1'b1;
    repeat (10) @(posedge clk);
    rd(8'h08, 32'h0);
    wb(1'b1, 8'h00, 32'h8, q);
    repeat (5) @(posedge clk);
    rd(8'h08, 32'h8);
    irq[3] <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b1, 8'h0c, 32'hffffffff, q);
    // nesting: line k at level 3-k
    wb(1'b1, 8'h20, 32'h004080c0, q);
    accept <= 1'b1;
    wb(1'b1, 8'h14, 32'h1, q);
    wb(1'b1, 8'h08, 32'h1, q);
    wb(1'b1, 8'h08, 32'h1, q);
    exp_act(9'h000, 3'h0);
    rd(8'h10, 32'h0041_0000);
    chk({31'h0, req}, 32'h0);
    rd(8'h08, 32'h1);
    wb(1'b1, 8'h14, 32'h0, q);
    exp_act(9'h010, 3'h1);
    rd(8'h08, 32'h0);
    for (int k = 1; k < 4; k++) begin
      wb(1'b1, 8'h08, 32'h1 << k, q);
      exp_act(9'h010 + 9'(k), 3'(k + 1));
    end
    wb(1'b1, 8'h08, 32'h2, q);
    exp_act(9'h013, 3'h4);
    rd(8'h08, 32'h2);
    ret();
    exp_act(9'h012, 3'h3);
    ret();
    exp_act(9'h011, 3'h2);
    ret();
    exp_act(9'h011, 3'h2);
    ret();
    exp_act(9'h010, 3'h1);
    ret();
    exp_act(9'h000, 3'h0);
    // fixed priorities outrank every configurable level
    accept <= 1'b0;
    wb(1'b1, 8'h08, 32'h8, q);
    rexc <= 1'b1;
    nmi <= 1'b1;
    hf <= 1'b1;
    @(posedge clk);
    {rexc, nmi, hf} <= 3'h0;
    repeat (8) @(posedge clk);
    chk({23'h0, enum_o}, 32'h1);
    accept <= 1'b1;
    exp_act(9'h001, 3'h1);
    ret();
    exp_act(9'h002, 3'h1);
    ret();
    exp_act(9'h003, 3'h1);
    ret();
    exp_act(9'h013, 3'h1);
    ret();
    exp_act(9'h000, 3'h0);
    chk({31'h0, req}, 32'h0);
    results();
  end
endmodule // interrupt_priority_pending_ctrl_tb
`default_nettype wire
